// ===== vcdac_pkg.sv
// Package for the DAC-register I2C target with its nonvolatile copy.
// Assumes a 250 MHz system clock; times become cycle counts here.
package vcdac_pkg;
  localparam logic [5:0] VCDAC_ADDR_MATCH = 6'h27;
  localparam int VCDAC_CLK_MHZ = 250;
  localparam int VCDAC_PROG_MAX_MS = 100;
  localparam int VCDAC_PROG_MAX_CYC = VCDAC_PROG_MAX_MS * 1000 * VCDAC_CLK_MHZ;
  localparam int VCDAC_PHASE_CYC_DFLT = 4096;
  localparam logic [2:0] VCDAC_MAX_TRIES = 3'h4;
  localparam logic [7:0] VCDAC_NV_RESET = 8'h00;

  typedef enum {VCDAC_IDLE, VCDAC_ADDR, VCDAC_AACK, VCDAC_WDATA, VCDAC_WACK,
                VCDAC_RDATA, VCDAC_RACK, VCDAC_IGNORE} vcdac_bus_t;
  typedef enum {VCDAC_P_LOAD, VCDAC_P_IDLE, VCDAC_P_ERASE, VCDAC_P_ECHK,
                VCDAC_P_WRITE, VCDAC_P_WCHK} vcdac_prog_t;

  // Handshake with the nonvolatile cell array.
  typedef struct packed {
    logic erase;
    logic write;
    logic [7:0] data;
  } vcdac_nv_cmd_t;

  typedef struct packed {
    logic done;
    logic ok;
  } vcdac_nv_rsp_t;
endpackage : vcdac_pkg

// ===== vcdac_i2c_eeprom_ctrl.sv
// DAC-register I2C target that copies the register into a nonvolatile byte on command.
// Assumes scl/sda come from pins (synchronised here) and the cell array answers on clk.
//
// Function
// - Write-protect high: address and data bytes are accepted and acted upon.
// - Write-protect low: no register change, no programming; still acks and reads.
// - Read returns register; write with select 1 writes; select 0 programs.
// - Respond only when the upper six address bits equal 100111.
// - Programming copies register to the nonvolatile byte only if supply is sufficient.
// - Started programming completes within 100 ms even if write-protect drops.
// - Erase then write, each retried up to four attempts.
// - Write: start, address with direction 0, ack, data MSB first, ack, stop.
// - Read: address with direction 1, ack, register sent MSB first, stop.
`timescale 1ns/1ps
`default_nettype none
module vcdac_i2c_eeprom_ctrl
  import vcdac_pkg::*;
#(
  parameter int PHASE_TIMEOUT = VCDAC_PHASE_CYC_DFLT
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Control and status
  input wire logic wp_n_i,
  input wire logic avdd_ok_i,
  output logic [7:0] dac_value,
  output logic prog_busy,
  output logic prog_fail,
  // Nonvolatile cell array
  input wire logic [7:0] nv_stored,
  output vcdac_pkg::vcdac_nv_cmd_t nv_cmd,
  input wire vcdac_pkg::vcdac_nv_rsp_t nv_rsp
);
  import vcdac_pkg::*;

  logic [1:0] scl_s_q, sda_s_q, wp_s_q, av_s_q;
  logic scl_p_q, sda_p_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      wp_s_q <= 2'h0;
      av_s_q <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      wp_s_q <= {wp_s_q[0], wp_n_i};
      av_s_q <= {av_s_q[0], avdd_ok_i};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  logic scl, sda, wp_hi, av_ok, scl_rise, scl_fall, start_c, stop_c;
  assign scl = scl_s_q[1];
  assign sda = sda_s_q[1];
  assign wp_hi = wp_s_q[1];
  assign av_ok = av_s_q[1];
  assign scl_rise = scl && !scl_p_q;
  assign scl_fall = !scl && scl_p_q;
  assign start_c = scl && scl_p_q && sda_p_q && !sda;
  assign stop_c = scl && scl_p_q && !sda_p_q && sda;

  // Bus state.
  vcdac_bus_t bs_q, bs_d;
  logic [7:0] sh_q, sh_d, dac_q, dac_d;
  logic [2:0] cnt_q, cnt_d;
  logic sel_q, sel_d, drv_q, drv_d, bit_q, bit_d, go_q, go_d;
  logic prog_start, loaded;

  always_comb
  begin
    bs_d = bs_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    drv_d = drv_q;
    bit_d = bit_q;
    go_d = 1'b0;
    dac_d = dac_q;
    if (!loaded)
      dac_d = nv_stored;
    if (start_c && loaded)
    begin
      bs_d = VCDAC_ADDR;
      cnt_d = 3'h7;
      drv_d = 1'b0;
    end
    else if (stop_c)
    begin
      bs_d = VCDAC_IDLE;
      drv_d = 1'b0;
    end
    else
    begin
      case (bs_q)
        VCDAC_ADDR, VCDAC_WDATA:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q - 3'h1;
          end
          // A byte is complete once eight rises have been shifted in.
          if (scl_fall && cnt_q == 3'h7 && bit_q)
          begin
            if (bs_q == VCDAC_ADDR)
            begin
              sel_d = sh_q[1];
              if (sh_q[7:2] == VCDAC_ADDR_MATCH)
              begin
                bs_d = VCDAC_AACK;
                drv_d = 1'b1;
              end
              else
                bs_d = VCDAC_IGNORE;
            end
            else
            begin
              bs_d = VCDAC_WACK;
              drv_d = 1'b1;
              if (wp_hi && sel_q)
                dac_d = sh_q;
              else if (wp_hi && !sel_q && !prog_busy)
                go_d = 1'b1;
            end
          end
        end
        VCDAC_AACK:
          if (scl_fall)
          begin
            if (sh_q[0])
            begin
              bs_d = VCDAC_RDATA;
              sh_d = {dac_q[6:0], 1'b0};
              bit_d = dac_q[7];
              cnt_d = 3'h7;
            end
            else
            begin
              bs_d = VCDAC_WDATA;
              drv_d = 1'b0;
              cnt_d = 3'h7;
            end
          end
        VCDAC_WACK:
          if (scl_fall)
          begin
            bs_d = VCDAC_IGNORE;
            drv_d = 1'b0;
          end
        VCDAC_RDATA:
          if (scl_fall)
          begin
            if (cnt_q == 3'h0)
            begin
              bs_d = VCDAC_RACK;
              drv_d = 1'b0;
            end
            else
            begin
              bit_d = sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q - 3'h1;
            end
          end
        VCDAC_RACK:
          if (scl_fall)
            bs_d = VCDAC_IGNORE;
        VCDAC_IDLE, VCDAC_IGNORE:
          drv_d = 1'b0;
        default:
          bs_d = VCDAC_IDLE;
      endcase
    end
    // Byte-complete flag: set on the eighth rise of a received byte.
    if ((bs_q == VCDAC_ADDR || bs_q == VCDAC_WDATA) && !start_c && !stop_c)
    begin
      if (scl_rise)
        bit_d = (cnt_q == 3'h0);
    end
    else if (bs_q != VCDAC_RDATA && bs_d != VCDAC_RDATA)
      bit_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bs_q <= VCDAC_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h7;
      sel_q <= 1'b0;
      drv_q <= 1'b0;
      bit_q <= 1'b0;
      go_q <= 1'b0;
      dac_q <= VCDAC_NV_RESET;
    end
    else
    begin
      bs_q <= bs_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      drv_q <= drv_d;
      bit_q <= bit_d;
      go_q <= go_d;
      dac_q <= dac_d;
    end
  end

  // Acks pull low; read bits drive low only for a zero (open drain).
  assign sda_o = 1'b0;
  assign sda_oe = drv_q && (bs_q == VCDAC_RDATA ? !bit_q : 1'b1);
  assign dac_value = dac_q;
  assign prog_start = go_q;

  // Programming sequencer; write-protect is not looked at once started.
  vcdac_prog_t ps_q, ps_d;
  logic [2:0] try_q, try_d;
  logic [7:0] img_q, img_d;
  logic [31:0] tmr_q, tmr_d;
  logic fail_q, fail_d;
  always_comb
  begin
    ps_d = ps_q;
    try_d = try_q;
    img_d = img_q;
    fail_d = fail_q;
    tmr_d = tmr_q + 32'h1;
    case (ps_q)
      VCDAC_P_LOAD:
        ps_d = VCDAC_P_IDLE;
      VCDAC_P_IDLE:
        if (prog_start && av_ok)
        begin
          img_d = dac_q;
          try_d = 3'h1;
          tmr_d = 32'h0;
          fail_d = 1'b0;
          ps_d = VCDAC_P_ERASE;
        end
      VCDAC_P_ERASE:
        ps_d = VCDAC_P_ECHK;
      VCDAC_P_ECHK:
        if (nv_rsp.done || tmr_q >= 32'(PHASE_TIMEOUT))
        begin
          tmr_d = 32'h0;
          if (nv_rsp.done && nv_rsp.ok)
          begin
            ps_d = VCDAC_P_WRITE;
            try_d = 3'h1;
          end
          else if (try_q == VCDAC_MAX_TRIES)
          begin
            fail_d = 1'b1;
            ps_d = VCDAC_P_IDLE;
          end
          else
          begin
            try_d = try_q + 3'h1;
            ps_d = VCDAC_P_ERASE;
          end
        end
      VCDAC_P_WRITE:
        ps_d = VCDAC_P_WCHK;
      VCDAC_P_WCHK:
        if (nv_rsp.done || tmr_q >= 32'(PHASE_TIMEOUT))
        begin
          tmr_d = 32'h0;
          if (nv_rsp.done && nv_rsp.ok)
            ps_d = VCDAC_P_IDLE;
          else if (try_q == VCDAC_MAX_TRIES)
          begin
            fail_d = 1'b1;
            ps_d = VCDAC_P_IDLE;
          end
          else
          begin
            try_d = try_q + 3'h1;
            ps_d = VCDAC_P_WRITE;
          end
        end
      default:
        ps_d = VCDAC_P_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ps_q <= VCDAC_P_LOAD;
      try_q <= 3'h0;
      img_q <= 8'h00;
      tmr_q <= 32'h0;
      fail_q <= 1'b0;
    end
    else
    begin
      ps_q <= ps_d;
      try_q <= try_d;
      img_q <= img_d;
      tmr_q <= tmr_d;
      fail_q <= fail_d;
    end
  end

  assign loaded = (ps_q != VCDAC_P_LOAD);
  assign prog_busy = (ps_q != VCDAC_P_IDLE) && loaded;
  assign prog_fail = fail_q;
  assign nv_cmd.erase = (ps_q == VCDAC_P_ERASE);
  assign nv_cmd.write = (ps_q == VCDAC_P_WRITE);
  assign nv_cmd.data = img_q;
endmodule : vcdac_i2c_eeprom_ctrl
`default_nettype wire

// ===== vcdac_i2c_master.sv
// I2C bus master model for the DAC-register target.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module vcdac_i2c_master (
  // Clock and bus
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Eight clocks a third of a bit outlast the block's input sync.
  task automatic wt();
    repeat (8) @(posedge clk);
  endtask : wt
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    wt();
    scl <= 1'h1;
    wt();
    r = sda;
    scl <= 1'h0;
    wt();
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'h1, r);
    ack = !r;
  endtask : xfer
  task automatic txn(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rx,
                     output logic ack);
    logic n;
    sda_low <= 1'h1;
    wt();
    scl <= 1'h0;
    wt();
    xfer(a, rx, ack);
    xfer(a[0] ? 8'hff : d, rx, n);
    sda_low <= 1'h1;
    wt();
    scl <= 1'h1;
    wt();
    sda_low <= 1'h0;
    wt();
  endtask : txn
endmodule : vcdac_i2c_master
`default_nettype wire

// ===== vcdac_ctrl_asserts.sv
// Port checks of the DAC-register I2C target, bound to its top module.
// Assumes SCL stays low several clocks around SDA changes.
`timescale 1ns/1ps
`default_nettype none
module vcdac_ctrl_chk
  import vcdac_pkg::*;
#(
  parameter int PHASE_TIMEOUT = VCDAC_PHASE_CYC_DFLT
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Control and status
  input wire logic wp_n_i,
  input wire logic avdd_ok_i,
  input wire logic [7:0] dac_value,
  input wire logic prog_busy,
  // Nonvolatile cell array
  input wire logic [7:0] nv_stored,
  input wire vcdac_pkg::vcdac_nv_cmd_t nv_cmd
);
  // Eight attempts, each cut off by the phase timeout, plus slack.
  localparam int BUSY_MAX = 8 * (PHASE_TIMEOUT + 16);
  logic [2:0] ers_q, ers_d;
  int busy_q, busy_d;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  always_comb
  begin
    ers_d = (prog_busy || nv_cmd.erase) ? ers_q + {2'h0, nv_cmd.erase} : 3'h0;
    busy_d = prog_busy ? busy_q + 1 : 0;
  end
  always_ff @(posedge clk)
  begin
    ers_q <= rst ? 3'h0 : ers_d;
    busy_q <= rst ? 0 : busy_d;
  end
  chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda drive moved with scl high");
  chk_sda_drain: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  chk_wp_dac_hold: assert property ((!wp_n_i)[*6] |=> $stable(dac_value))
    else $error("dac changed while protected");
  chk_supply_start: assert property ($rose(prog_busy) |-> avdd_ok_i && wp_n_i)
    else $error("program started when barred");
  chk_prog_time: assert property (busy_q < BUSY_MAX)
    else $error("program too long");
  chk_erase_tries: assert property (ers_q <= VCDAC_MAX_TRIES)
    else $error("too many erase attempts");
  chk_erase_first: assert property (nv_cmd.write |-> ers_q != 3'h0)
    else $error("write with no erase");
  chk_reset_load: assert property ($fell(rst) |-> ##[1:2] dac_value == nv_stored)
    else $error("stored byte not loaded");
  cover property ($rose(prog_busy));
  cover property ($rose(sda_oe));
  cover property (nv_cmd.write);
endmodule : vcdac_ctrl_chk
bind vcdac_i2c_eeprom_ctrl vcdac_ctrl_chk #(.PHASE_TIMEOUT(PHASE_TIMEOUT)) u_chk (.*);
`default_nettype wire

// ===== testbench.sv
// Bench for the DAC-register I2C target with a cell array model.
// Assumes the checker binds itself to the block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vcdac_pkg::*;
  logic clk, rst, wp_n_i, avdd_ok_i, scl_i, m_low, sda_oe, sda_o, prog_busy, prog_fail, ak;
  logic [7:0] dac_value, rx;
  logic [7:0] nv_stored = 8'h5a;
  vcdac_nv_cmd_t nv_cmd;
  vcdac_nv_rsp_t nv_rsp = '0;
  int fail_count = 0, samples_checked = 0, nfail = 0, dly = 0, cyc = 0;
  wire sda_i = !(m_low || (sda_oe && !sda_o));
  vcdac_i2c_eeprom_ctrl #(.PHASE_TIMEOUT(64)) uut (.*);
  vcdac_i2c_master mst (.clk(clk), .sda(sda_i), .scl(scl_i), .sda_low(m_low));
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Each phase answers late so programming outlasts the stop; nfail attempts fail.
  always @(posedge clk)
  begin
    if (nv_cmd.erase || nv_cmd.write)
      dly <= 40;
    else if (dly > 0)
      dly <= dly - 1;
    nv_rsp <= {dly == 1, nfail == 0};
    if (dly == 1 && nfail > 0)
      nfail <= nfail - 1;
    if (nv_cmd.write && nfail == 0)
      nv_stored <= nv_cmd.data;
  end
  always @(posedge clk)
    if (++cyc == 30000)
    begin
      fail_count++;
      finish_test();
    end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic txn(input logic [7:0] a, input logic [7:0] d, input logic ea);
    mst.txn(a, d, rx, ak);
    chk({7'h00, ak}, {7'h00, ea});
  endtask : txn
  task automatic wait_idle();
    for (int n = 0; n < 500 && prog_busy !== 1'h0; n++)
      @(posedge clk);
  endtask : wait_idle
  task automatic finish_test();
    $display("checked %0d bad %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial
  begin
    rst = 1'h1;
    wp_n_i = 1'h1;
    avdd_ok_i = 1'h1;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    chk(dac_value, 8'h5a);
    txn(8'h9f, 8'h00, 1'h1);
    chk(rx, 8'h5a);
    txn(8'h9e, 8'ha5, 1'h1);
    chk(dac_value, 8'ha5);
    txn(8'h9d, 8'h00, 1'h1);
    chk(rx, 8'ha5);
    $display("test read write done");
    txn(8'h1e, 8'h11, 1'h0);
    txn(8'h9a, 8'h22, 1'h0);
    txn(8'hde, 8'h33, 1'h0);
    chk(dac_value, 8'ha5);
    $display("test address done");
    wp_n_i <= 1'h0;
    txn(8'h9e, 8'h3c, 1'h1);
    txn(8'h9c, 8'h00, 1'h1);
    txn(8'h9f, 8'h00, 1'h1);
    chk(rx, 8'ha5);
    chk(nv_stored, 8'h5a);
    $display("test protect done");
    wp_n_i <= 1'h1;
    avdd_ok_i <= 1'h0;
    txn(8'h9c, 8'h00, 1'h1);
    chk(nv_stored, 8'h5a);
    $display("test supply done");
    avdd_ok_i <= 1'h1;
    nfail <= 2;
    txn(8'h9c, 8'h00, 1'h1);
    wp_n_i <= 1'h0;
    repeat (8) @(posedge clk);
    chk({7'h00, prog_busy}, 8'h01);
    wait_idle();
    chk({7'h00, prog_busy}, 8'h00);
    chk(nv_stored, 8'ha5);
    chk({7'h00, prog_fail}, 8'h00);
    $display("test program done");
    wp_n_i <= 1'h1;
    nfail <= 4;
    txn(8'h9e, 8'h77, 1'h1);
    txn(8'h9c, 8'h00, 1'h1);
    wait_idle();
    chk({7'h00, prog_fail}, 8'h01);
    chk(nv_stored, 8'ha5);
    txn(8'h9c, 8'h00, 1'h1);
    wait_idle();
    chk(nv_stored, 8'h77);
    $display("test retry limit done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
